// ---- inc/mior_consts.svh ----
`ifndef MIOR_CONSTS_SVH
`define MIOR_CONSTS_SVH

`define MIOR_OP_DUAL_OUT 8'h3b
`define MIOR_OP_QUAD_OUT 8'h6b
`define MIOR_OP_DUAL_IO 8'hbb
`define MIOR_OP_QUAD_IO 8'heb
`define MIOR_LANES_1 3'h1
`define MIOR_LANES_2 3'h2
`define MIOR_LANES_4 3'h4
`define MIOR_OP_CLK_SPI 5'h8
`define MIOR_OP_CLK_QPI 5'h2
`define MIOR_ADDR_BITS 5'h18
`define MIOR_MODE_BITS 5'h8
`define MIOR_BYTE_BITS 5'h8
`define MIOR_DUMMY_FAST 4'h8
`define MIOR_DUMMY_QIO_SPI 4'h4
`define MIOR_MODE_CLK_QPI 4'h2
`define MIOR_QPI_DUMMY_RST 4'h2
`define MIOR_CONT_KEEP 2'h2
`define MIOR_WRAP_DIS_RST 1'h1
`define MIOR_WRAP_LEN_RST 2'h0
`define MIOR_WRAP_MIN_BYTES 24'h8
`define MIOR_IDLE_BYTE 8'hff
`define MIOR_OE_OFF 4'hf
`define MIOR_OE_DUAL 4'hc
`define MIOR_OE_QUAD 4'h0
`define MIOR_OE_SINGLE 4'he
`define MIOR_CNT_LAST 5'h1
`define MIOR_FIFO_DEPTH 4

`endif

// ---- inc/mior_pkg.sv ----
`default_nettype none
package mior_pkg;

    typedef enum logic [2:0] {
        MIOR_IDLE,
        MIOR_OPCODE,
        MIOR_ADDR,
        MIOR_MODE,
        MIOR_DUMMY,
        MIOR_DATA,
        MIOR_IGNORE
    } mior_state_t;

    typedef struct packed {
        logic valid;
        logic quad_io;
        logic mode_on;
        logic [2:0] addr_lanes;
        logic [2:0] data_lanes;
        logic [3:0] dummy;
    } mior_cmd_t;

endpackage : mior_pkg
`default_nettype wire

// ---- hw/mior_fifo.sv ----
`default_nettype none
module mior_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_check
        $error("mior_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != CNT_W'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_ready_i & out_valid_o;

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // A flush drops whatever is queued so a new frame never sees stale bytes.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || flush_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= PTR_W'(wr_ptr + 1'h1);
            end
            if (pop)
            begin
                rd_ptr <= PTR_W'(rd_ptr + 1'h1);
            end
            if (push && !pop)
            begin
                count <= CNT_W'(count + 1'h1);
            end
            else if (pop && !push)
            begin
                count <= CNT_W'(count - 1'h1);
            end
        end
    end

endmodule : mior_fifo
`default_nettype wire

// ---- hw/mior_flash_read.sv ----
`include "mior_consts.svh"
`default_nettype none
module mior_flash_read
    import mior_pkg::*;
#(
    parameter int FIFO_DEPTH = `MIOR_FIFO_DEPTH
)
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic io_line_0_i,
    input wire logic io_line_1_i,
    input wire logic io_line_2_i,
    input wire logic io_line_3_i,
    output logic io_line_0_o,
    output logic io_line_1_o,
    output logic io_line_2_o,
    output logic io_line_3_o,
    output logic io_line_0_oe_n_o,
    output logic io_line_1_oe_n_o,
    output logic io_line_2_oe_n_o,
    output logic io_line_3_oe_n_o,
    input wire logic quad_command_mode_i,
    input wire logic wrap_load_i,
    input wire logic wrap_disable_bit_i,
    input wire logic [1:0] wrap_length_bits_i,
    input wire logic read_param_load_i,
    input wire logic [1:0] read_param_i,
    input wire logic soft_reset_i,
    output logic continuous_read_o,
    output logic [3:0] qpi_dummy_clocks_o,
    output logic [23:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_data_i
);

    // ************************************************************
    // Parameter check
    // ************************************************************

    if (FIFO_DEPTH < 2)
    begin : g_check
        $error("mior_flash_read needs a prefetch depth of at least two");
    end

    // ************************************************************
    // Helper functions
    // ************************************************************

    function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                             input logic [3:0] io,
                                             input logic [2:0] lanes);
        logic [23:0] r;
        case (lanes)
            `MIOR_LANES_2: r = {sh[21:0], io[1:0]};
            `MIOR_LANES_4: r = {sh[19:0], io};
            default: r = {sh[22:0], io[0]};
        endcase
        return r;
    endfunction : shift_in

    function automatic logic [4:0] phase_clocks(input logic [4:0] bits,
                                                input logic [2:0] lanes);
        logic [4:0] r;
        case (lanes)
            `MIOR_LANES_2: r = bits >> 1;
            `MIOR_LANES_4: r = bits >> 2;
            default: r = bits;
        endcase
        return r;
    endfunction : phase_clocks

    // The top bits of the byte go out first, the highest bit on the highest line.
    function automatic logic [3:0] out_group(input logic [7:0] b,
                                             input logic [2:0] lanes);
        logic [3:0] r;
        case (lanes)
            `MIOR_LANES_2: r = {2'h0, b[7:6]};
            `MIOR_LANES_4: r = b[7:4];
            default: r = {3'h0, b[7]};
        endcase
        return r;
    endfunction : out_group

    function automatic logic [7:0] shift_out(input logic [7:0] b,
                                             input logic [2:0] lanes);
        logic [7:0] r;
        case (lanes)
            `MIOR_LANES_2: r = {b[5:0], 2'h0};
            `MIOR_LANES_4: r = {b[3:0], 4'h0};
            default: r = {b[6:0], 1'h0};
        endcase
        return r;
    endfunction : shift_out

    function automatic logic [3:0] out_enable_n(input logic [2:0] lanes);
        logic [3:0] r;
        case (lanes)
            `MIOR_LANES_2: r = `MIOR_OE_DUAL;
            `MIOR_LANES_4: r = `MIOR_OE_QUAD;
            default: r = `MIOR_OE_SINGLE;
        endcase
        return r;
    endfunction : out_enable_n

    function automatic logic [23:0] next_addr(input logic [23:0] a,
                                              input logic wrap,
                                              input logic [1:0] len);
        logic [23:0] mask;
        logic [23:0] inc;
        mask = (`MIOR_WRAP_MIN_BYTES << len) - 24'h1;
        inc = a + 24'h1;
        if (wrap)
        begin
            return (a & ~mask) | (inc & mask);
        end
        return inc;
    endfunction : next_addr

    function automatic mior_cmd_t decode(input logic [7:0] op,
                                         input logic quad_command_mode,
                                         input logic [3:0] qdummy);
        mior_cmd_t c;
        c = '0;
        case (op)
            `MIOR_OP_DUAL_OUT:
            begin
                c.valid = !quad_command_mode;
                c.addr_lanes = `MIOR_LANES_1;
                c.data_lanes = `MIOR_LANES_2;
                c.dummy = `MIOR_DUMMY_FAST;
            end
            `MIOR_OP_QUAD_OUT:
            begin
                c.valid = !quad_command_mode;
                c.addr_lanes = `MIOR_LANES_1;
                c.data_lanes = `MIOR_LANES_4;
                c.dummy = `MIOR_DUMMY_FAST;
            end
            `MIOR_OP_DUAL_IO:
            begin
                c.valid = !quad_command_mode;
                c.mode_on = 1'h1;
                c.addr_lanes = `MIOR_LANES_2;
                c.data_lanes = `MIOR_LANES_2;
            end
            // Quad I/O read, mode clocks count as dummy only in quad command mode.
            `MIOR_OP_QUAD_IO:
            begin
                c.valid = 1'h1;
                c.quad_io = 1'h1;
                c.mode_on = 1'h1;
                c.addr_lanes = `MIOR_LANES_4;
                c.data_lanes = `MIOR_LANES_4;
                c.dummy = quad_command_mode ? qdummy - `MIOR_MODE_CLK_QPI : `MIOR_DUMMY_QIO_SPI;
            end
            default: c.valid = 1'h0;
        endcase
        // Only the quad I/O read stays valid in quad command mode.
        return c;
    endfunction : decode

    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************

    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic [3:0] io_s1;
    logic [3:0] io_s2;

    // Clock, select and data lines share the same delay, so a sampled rising
    // edge still sees the data that the host set up before it.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            sclk_s1 <= 1'h0;
            sclk_s2 <= 1'h0;
            sclk_s3 <= 1'h0;
            cs_s1 <= 1'h1;
            cs_s2 <= 1'h1;
            cs_s3 <= 1'h1;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end
        else
        begin
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            io_s1 <= {io_line_3_i, io_line_2_i, io_line_1_i, io_line_0_i};
            io_s2 <= io_s1;
        end
    end

    logic rise;
    logic fall;
    logic frame_start;

    // Rising edges sample, falling edges drive.
    assign rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
    assign fall = ~sclk_s2 & sclk_s3 & ~cs_s2;
    assign frame_start = ~cs_s2 & cs_s3;

    // ************************************************************
    // Configuration held by the device
    // ************************************************************

    logic wrap_dis;
    logic [1:0] wrap_len;
    logic [3:0] qpi_dummy;

    // Wrapping starts disabled; wrap bits loaded together.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            wrap_dis <= `MIOR_WRAP_DIS_RST;
            wrap_len <= `MIOR_WRAP_LEN_RST;
        end
        else if (wrap_load_i)
        begin
            wrap_dis <= wrap_disable_bit_i;
            wrap_len <= wrap_length_bits_i;
        end
    end

    // Default dummy count; parameter field sets 2 to 8.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || soft_reset_i)
        begin
            qpi_dummy <= `MIOR_QPI_DUMMY_RST;
        end
        else if (read_param_load_i)
        begin
            qpi_dummy <= `MIOR_QPI_DUMMY_RST + {1'h0, read_param_i, 1'h0};
        end
    end

    assign qpi_dummy_clocks_o = qpi_dummy;

    // ************************************************************
    // Command sequencer
    // ************************************************************

    mior_state_t state;
    mior_cmd_t cmd;
    logic [4:0] cnt;
    logic [23:0] shreg;
    logic [23:0] next_sh;
    logic [2:0] in_lanes;
    logic last;
    logic cont;
    logic cont_dual;
    mior_cmd_t op_cmd;
    mior_cmd_t cont_cmd;

    assign in_lanes = (state == MIOR_OPCODE)
                      ? (quad_command_mode_i ? `MIOR_LANES_4 : `MIOR_LANES_1)
                      : cmd.addr_lanes;
    assign next_sh = shift_in(shreg, io_s2, in_lanes);
    assign last = (cnt == `MIOR_CNT_LAST);
    assign op_cmd = decode(next_sh[7:0], quad_command_mode_i, qpi_dummy);
    assign cont_cmd = decode(cont_dual ? `MIOR_OP_DUAL_IO : `MIOR_OP_QUAD_IO,
                             quad_command_mode_i, qpi_dummy);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            state <= MIOR_IDLE;
            cmd <= '0;
            cnt <= '0;
            shreg <= '0;
        end
        // Select high ends the frame at once.
        else if (cs_s2)
        begin
            state <= MIOR_IDLE;
        end
        else if (frame_start)
        begin
            shreg <= '0;
            if (cont)
            begin
                cmd <= cont_cmd;
                state <= MIOR_ADDR;
                cnt <= phase_clocks(`MIOR_ADDR_BITS, cont_cmd.addr_lanes);
            end
            else
            begin
                state <= MIOR_OPCODE;
                cnt <= quad_command_mode_i ? `MIOR_OP_CLK_QPI : `MIOR_OP_CLK_SPI;
            end
        end
        else if (rise)
        begin
            case (state)
                MIOR_OPCODE:
                begin
                    shreg <= next_sh;
                    cnt <= cnt - 5'h1;
                    if (last)
                    begin
                        cmd <= op_cmd;
                        cnt <= phase_clocks(`MIOR_ADDR_BITS, op_cmd.addr_lanes);
                        state <= op_cmd.valid ? MIOR_ADDR : MIOR_IGNORE;
                    end
                end
                MIOR_ADDR:
                begin
                    shreg <= next_sh;
                    cnt <= cnt - 5'h1;
                    if (last && cmd.mode_on)
                    begin
                        // Eight mode bits follow the address.
                        state <= MIOR_MODE;
                        cnt <= phase_clocks(`MIOR_MODE_BITS, cmd.addr_lanes);
                    end
                    else if (last)
                    begin
                        state <= (cmd.dummy != 4'h0) ? MIOR_DUMMY : MIOR_DATA;
                        cnt <= {1'h0, cmd.dummy};
                    end
                end
                MIOR_MODE:
                begin
                    shreg <= next_sh;
                    cnt <= cnt - 5'h1;
                    // Zero remaining dummy clocks leads straight to data.
                    if (last)
                    begin
                        state <= (cmd.dummy != 4'h0) ? MIOR_DUMMY : MIOR_DATA;
                        cnt <= {1'h0, cmd.dummy};
                    end
                end
                // Dummy clocks only count; the lines are not looked at.
                MIOR_DUMMY:
                begin
                    cnt <= cnt - 5'h1;
                    if (last)
                    begin
                        state <= MIOR_DATA;
                    end
                end
                default:
                begin
                    state <= state;
                end
            endcase
        end
    end

    // Only mode bits five and four decide; ones exit.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            cont <= 1'h0;
            cont_dual <= 1'h0;
        end
        else if (!cs_s2 && rise && state == MIOR_MODE && last)
        begin
            cont <= (next_sh[5:4] == `MIOR_CONT_KEEP);
            cont_dual <= !cmd.quad_io;
        end
    end

    assign continuous_read_o = cont;

    // ************************************************************
    // Memory prefetch
    // ************************************************************

    logic fetch_on;
    logic wrap_on;
    logic [23:0] fetch_addr;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;

    // Fetching starts as soon as the address is in, so the mode and dummy
    // clocks hide the array latency; a full queue stalls the fetch.
    assign mem_rd_o = fetch_on & fifo_in_ready;
    assign mem_addr_o = fetch_addr;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i || cs_s2)
        begin
            fetch_on <= 1'h0;
            wrap_on <= 1'h0;
            fetch_addr <= '0;
        end
        else if (rise && state == MIOR_ADDR && last)
        begin
            fetch_on <= 1'h1;
            fetch_addr <= next_sh;
            // Wrap only for quad I/O reads outside quad command mode.
            wrap_on <= cmd.quad_io & !quad_command_mode_i & !wrap_dis;
        end
        // Step to the next byte after each fetch.
        else if (mem_rd_o && mem_ack_i)
        begin
            fetch_addr <= next_addr(fetch_addr, wrap_on, wrap_len);
        end
    end

    mior_fifo
    #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    )
    u_fifo
    (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .flush_i(cs_s2),
        .in_valid_i(mem_rd_o & mem_ack_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem_data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ************************************************************
    // Data output
    // ************************************************************

    logic [3:0] io_out;
    logic [3:0] oe_n;
    logic [7:0] obyte;
    logic [4:0] grp;
    logic [7:0] cur_byte;

    // An empty queue means the host clocks faster than memory answers; the
    // byte is then sent as all ones rather than stalling the link.
    assign cur_byte = (grp != 5'h0) ? obyte
                      : (fifo_out_valid ? fifo_out_data : `MIOR_IDLE_BYTE);
    assign fifo_out_ready = fall & (state == MIOR_DATA) & (grp == 5'h0);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            io_out <= 4'h0;
            oe_n <= `MIOR_OE_OFF;
            obyte <= 8'h0;
            grp <= 5'h0;
        end
        // Drivers released whenever no data phase runs.
        else if (cs_s2 || state != MIOR_DATA)
        begin
            oe_n <= `MIOR_OE_OFF;
            grp <= 5'h0;
        end
        // Host has let go before this first falling edge.
        else if (fall)
        begin
            // Most significant group first on the highest lines.
            io_out <= out_group(cur_byte, cmd.data_lanes);
            obyte <= shift_out(cur_byte, cmd.data_lanes);
            oe_n <= out_enable_n(cmd.data_lanes);
            grp <= (grp == 5'h0)
                   ? phase_clocks(`MIOR_BYTE_BITS, cmd.data_lanes) - 5'h1
                   : grp - 5'h1;
        end
    end

    assign io_line_0_o = io_out[0];
    assign io_line_1_o = io_out[1];
    assign io_line_2_o = io_out[2];
    assign io_line_3_o = io_out[3];
    assign io_line_0_oe_n_o = oe_n[0];
    assign io_line_1_oe_n_o = oe_n[1];
    assign io_line_2_oe_n_o = oe_n[2];
    assign io_line_3_oe_n_o = oe_n[3];

endmodule : mior_flash_read
`default_nettype wire

// ---- test/mior_checker.sv ----
`default_nettype none
module mior_checker
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic io_line_0_oe_n_o,
    input wire logic io_line_1_oe_n_o,
    input wire logic io_line_2_oe_n_o,
    input wire logic io_line_3_oe_n_o,
    input wire logic read_param_load_i,
    input wire logic [1:0] read_param_i,
    input wire logic soft_reset_i,
    input wire logic [3:0] qpi_dummy_clocks_o,
    input wire logic mem_rd_o,
    input wire logic mem_ack_i,
    input wire logic [23:0] mem_addr_o,
    input wire logic continuous_read_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [3:0] oe_n = {io_line_3_oe_n_o, io_line_2_oe_n_o, io_line_1_oe_n_o,
        io_line_0_oe_n_o};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // ****
    // Checks
    // ****
    a_idle_release: assert property (cs_n_i [*6] |-> oe_n == 4'hf)
        else $error("lines driven after select high");
    a_drive_in_frame: assert property (oe_n != 4'hf |-> !$past(cs_n_i, 6))
        else $error("lines driven outside a frame");
    a_reset_state: assert property ($rose(rstn_i) |-> qpi_dummy_clocks_o == 4'h2
        && !continuous_read_o && !mem_rd_o) else $error("bad state after reset");
    a_soft_reset: assert property (soft_reset_i |=> qpi_dummy_clocks_o == 4'h2)
        else $error("dummy count not restored");
    a_param_load: assert property (read_param_load_i && !soft_reset_i |=>
        qpi_dummy_clocks_o == 4'({$past(read_param_i), 1'b1}) + 4'h1)
        else $error("dummy count not loaded");
    a_param_hold: assert property (!read_param_load_i && !soft_reset_i |=>
        $stable(qpi_dummy_clocks_o)) else $error("dummy count moved");
    a_addr_step: assert property (mem_rd_o && mem_ack_i |=>
        mem_addr_o[2:0] == $past(mem_addr_o[2:0]) + 3'h1) else $error("address not stepped");
    a_cont_in_frame: assert property ($changed(continuous_read_o) |->
        !$past(cs_n_i, 3)) else $error("continuous state changed outside a frame");
    c_stall: cover property (mem_rd_o && !mem_ack_i);
    c_quad: cover property (oe_n == 4'h0);
    c_cont: cover property ($rose(continuous_read_o));
endmodule : mior_checker
bind mior_flash_read mior_checker chk_i (.sys_clk_i, .rstn_i, .cs_n_i, .io_line_0_oe_n_o,
    .io_line_1_oe_n_o, .io_line_2_oe_n_o, .io_line_3_oe_n_o, .read_param_load_i,
    .read_param_i, .soft_reset_i, .qpi_dummy_clocks_o, .mem_rd_o, .mem_ack_i, .mem_addr_o,
    .continuous_read_o);
`default_nettype wire

// ---- test/mior_host_model.sv ----
`default_nettype none
module mior_host_model
(
    input wire logic sys_clk_i,
    input wire logic [3:0] io_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] io_o,
    output logic [3:0] io_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Host side of the link
    // ****
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        io_o = 4'h0;
        io_en_o = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic start();
        cs_n_o <= 1'b0;
        tick(4);
    endtask : start
    // Lines change while the clock is low, so the rising edge sees settled bits.
    task automatic send(input logic [31:0] v, input int n, input int w);
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk_o <= 1'b0;
            io_en_o <= 4'((1 << w) - 1);
            io_o <= 4'(v >> (i * w));
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
        end
    endtask : send
    task automatic recv(output logic [31:0] v, input int n, input int w);
        v = 32'h0;
        io_en_o <= 4'h0;
        tick(1);
        for (int i = 0; i < n; i++)
        begin
            sclk_o <= 1'b0;
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
            v = (v << w) | 32'(io_i & 4'((1 << w) - 1));
        end
    endtask : recv
    task automatic stop();
        tick(1);
        cs_n_o <= 1'b1;
        tick(8);
    endtask : stop
endmodule : mior_host_model
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rstn_i, quad_command_mode_i, wrap_disable_bit_i, mem_ack_i;
    logic [2:0] ld;
    logic [1:0] wrap_length_bits_i, read_param_i;
    logic [31:0] got;
    int cyc, failures, compares, drv, n0;
    wire logic cs_n_i, sclk_i, mem_rd_o, continuous_read_o;
    wire logic [3:0] qpi_dummy_clocks_o, ho, hen, oe_n, dv, lvl;
    wire logic [23:0] mem_addr_o;
    function automatic logic [7:0] f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : f
    wire logic [7:0] mem_data_i = f(mem_addr_o);
    // A released line shows a pattern that changes every cycle.
    assign lvl = (~oe_n & dv) | (oe_n & hen & ho) | (oe_n & ~hen & {4{cyc[0]}});
    mior_flash_read uut (.sys_clk_i, .rstn_i, .cs_n_i, .sclk_i, .quad_command_mode_i,
        .io_line_0_i(lvl[0]), .io_line_1_i(lvl[1]), .io_line_2_i(lvl[2]), .io_line_3_i(lvl[3]),
        .io_line_0_o(dv[0]), .io_line_1_o(dv[1]), .io_line_2_o(dv[2]), .io_line_3_o(dv[3]),
        .io_line_0_oe_n_o(oe_n[0]), .io_line_1_oe_n_o(oe_n[1]), .io_line_2_oe_n_o(oe_n[2]),
        .io_line_3_oe_n_o(oe_n[3]), .wrap_load_i(ld[0]), .wrap_disable_bit_i,
        .wrap_length_bits_i, .read_param_load_i(ld[1]), .read_param_i, .soft_reset_i(ld[2]),
        .continuous_read_o, .qpi_dummy_clocks_o, .mem_addr_o, .mem_rd_o, .mem_ack_i,
        .mem_data_i);
    mior_host_model host (.sys_clk_i, .io_i(lvl), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .io_o(ho),
        .io_en_o(hen));
    // ****
    // Tasks
    // ****
    function automatic logic [31:0] seq(input logic [23:0] a, input int n);
        seq = 32'h0;
        for (int i = 0; i < n; i++)
            seq = (seq << 8) | 32'(f(a + 24'(i)));
    endfunction : seq
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
        $display("test %0d done", compares);
    endtask : chk
    task automatic pl(input logic [2:0] k);
        @(posedge sys_clk_i);
        ld <= k;
        @(posedge sys_clk_i);
        ld <= 3'h0;
        @(posedge sys_clk_i);
    endtask : pl
    task automatic rd(input logic c, input logic [7:0] op, input logic [23:0] a,
        input logic [7:0] m, input int dm, input int nb);
        int aw;
        int dw;
        aw = (op == 8'h3b || op == 8'h6b) ? 1 : (op == 8'hbb) ? 2 : 4;
        dw = (op == 8'h3b || op == 8'hbb) ? 2 : 4;
        host.start();
        if (!c)
            host.send(32'(op), quad_command_mode_i ? 2 : 8, quad_command_mode_i ? 4 : 1);
        host.send(32'(a), 24 / aw, aw);
        if (aw > 1)
            host.send(32'(m), 8 / aw, aw);
        host.send(32'h5a5a5a5a, dm, 4);
        host.recv(got, nb * 8 / dw, dw);
        host.stop();
    endtask : rd
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // Memory stalls two cycles in four and the ceiling is far above the run length.
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        mem_ack_i <= cyc[1];
        drv <= drv + int'(oe_n != 4'hf);
        if (cyc == 40000)
        begin
            failures++;
            summarize();
        end
    end
    initial
    begin
        rstn_i = 1'b0;
        ld = 3'h0;
        quad_command_mode_i = 1'b0;
        wrap_disable_bit_i = 1'b1;
        wrap_length_bits_i = 2'h0;
        read_param_i = 2'h0;
        mem_ack_i = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk(32'(qpi_dummy_clocks_o), 32'h2);
        rd(1'b0, 8'h3b, 24'h000010, 8'h00, 8, 2);
        chk(got, seq(24'h000010, 2));
        rd(1'b0, 8'h6b, 24'h0000fe, 8'h00, 8, 4);
        chk(got, seq(24'h0000fe, 4));
        rd(1'b0, 8'hbb, 24'h000123, 8'h2a, 0, 2);
        chk(got, seq(24'h000123, 2));
        chk(32'(continuous_read_o), 32'h1);
        rd(1'b1, 8'hbb, 24'h000200, 8'hff, 0, 2);
        chk(got, seq(24'h000200, 2));
        chk(32'(continuous_read_o), 32'h0);
        rd(1'b0, 8'heb, 24'h000106, 8'hff, 4, 4);
        chk(got, seq(24'h000106, 4));
        wrap_disable_bit_i <= 1'b0;
        pl(3'h1);
        rd(1'b0, 8'heb, 24'h000106, 8'h20, 4, 4);
        chk(got, {f(24'h106), f(24'h107), f(24'h100), f(24'h101)});
        wrap_length_bits_i <= 2'h1;
        pl(3'h1);
        rd(1'b1, 8'heb, 24'h00013e, 8'hff, 4, 4);
        chk(got, {f(24'h13e), f(24'h13f), f(24'h130), f(24'h131)});
        quad_command_mode_i <= 1'b1;
        rd(1'b0, 8'heb, 24'h0001fe, 8'hff, 0, 4);
        chk(got, seq(24'h0001fe, 4));
        read_param_i <= 2'h3;
        pl(3'h2);
        chk(32'(qpi_dummy_clocks_o), 32'h8);
        rd(1'b0, 8'heb, 24'h000040, 8'h20, 6, 2);
        chk(got, seq(24'h000040, 2));
        rd(1'b1, 8'heb, 24'h000050, 8'hff, 6, 2);
        chk(got, seq(24'h000050, 2));
        pl(3'h4);
        chk(32'(qpi_dummy_clocks_o), 32'h2);
        n0 = drv;
        rd(1'b0, 8'h3b, 24'h000010, 8'h00, 8, 2);
        chk(32'(drv - n0), 32'h0);
        summarize();
    end
endmodule : testbench
`default_nettype wire
